// *** src/hwas_cfg.svh ***
// Register map, field positions, reset values and codes for the selector
`ifndef HWAS_CFG_SVH
`define HWAS_CFG_SVH

`define HWAS_GEN_COUNT      3
`define HWAS_AXIS_COUNT     4
`define HWAS_POS_WIDTH      16

// Register indices; byte address is space base plus four times the index
`define HWAS_IDX_X_SEL      12'h0074
`define HWAS_IDX_Z_SEL      12'h0075
`define HWAS_IDX_GEN_ASSIGN 12'h0075
`define HWAS_IDX_THIRD_SEL  12'h0076
`define HWAS_IDX_FOURTH_SEL 12'h0077
`define HWAS_IDX_GAIN_DIR   12'h0182
`define HWAS_IDX_CONFIG     12'h001F
`define HWAS_IDX_POS0       12'h0100
`define HWAS_IDX_MAP        12'h0104

`define HWAS_DGN_BASE       12'h0000
`define HWAS_PRM_BASE       12'h0800
`define HWAS_DGN_ADDR(i)    (`HWAS_DGN_BASE + ((i) << 2))
`define HWAS_PRM_ADDR(i)    (`HWAS_PRM_BASE + ((i) << 2))

// Field positions
`define HWAS_SEL_BIT        7
`define HWAS_CFG_SLE_BIT    0
`define HWAS_CFG_SPECB_BIT  1
`define HWAS_CFG_NGEN_LSB   2
`define HWAS_CFG_THIRD_BIT  5

// Reset values and codes
`define HWAS_CONFIG_RST     8'h04
`define HWAS_ASSIGN_RST     8'h00
`define HWAS_GAIN_DIR_RST   8'h00
`define HWAS_MODE_HANDLE    3'h1

`endif

// *** src/hwas_pkg.sv ***
// Shared types of the handwheel axis selector
`default_nettype none
package hwas_pkg;
    typedef logic [1:0] hwas_gen_type;
    typedef logic [3:0] hwas_axis_vec_type;
    typedef logic [7:0] hwas_byte_type;
endpackage
`default_nettype wire

// *** src/hwas_quad_decoder.sv ***
// Quadrature decoder for one handwheel generator
`default_nettype none
module hwas_quad_decoder
(
    input  wire logic core_clk,
    input  wire logic resetn,
    input  wire logic phase_a_in,
    input  wire logic phase_b_in,
    output logic      step_pulse,
    output logic      step_dir
);
    logic [1:0] meta_q;
    logic [1:0] sync_q;
    logic [1:0] prev_q;
    logic       step_q;
    logic       step_d;
    logic       dir_q;
    logic       dir_d;

    always_comb
    begin
        // Both phases moving at once is a skipped step: dropped
        step_d = (sync_q != prev_q) && (^(sync_q ^ prev_q));
        dir_d  = step_d ? (prev_q[1] ^ sync_q[0]) : dir_q;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_q <= 2'h0;
            sync_q <= 2'h0;
            prev_q <= 2'h0;
            step_q <= 1'b0;
            dir_q  <= 1'b0;
        end
        else
        begin
            meta_q <= {phase_a_in, phase_b_in};
            sync_q <= meta_q;
            prev_q <= sync_q;
            step_q <= step_d;
            dir_q  <= dir_d;
        end
    end

    assign step_pulse = step_q;
    assign step_dir   = dir_q;
endmodule
`default_nettype wire

// *** src/hwas_selector.sv ***
// Handwheel axis selector: select decode, axis mapping, APB registers
`include "hwas_cfg.svh"
`default_nettype none

module hwas_selector
(
    input  wire logic                      core_clk,
    input  wire logic                      resetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      x_axis_select,
    input  wire logic                      z_axis_select,
    input  wire logic                      third_axis_select,
    input  wire logic                      fourth_axis_select,
    input  wire logic                      z_gen_select_hi,
    input  wire logic                      z_gen_select_lo,
    input  wire logic                      mode_code_bit2,
    input  wire logic                      mode_code_bit1,
    input  wire logic                      mode_code_bit0,
    input  wire logic [`HWAS_GEN_COUNT-1:0] phase_a_in,
    input  wire logic [`HWAS_GEN_COUNT-1:0] phase_b_in,
    output logic      [`HWAS_AXIS_COUNT-1:0] axis_step,
    output logic      [`HWAS_AXIS_COUNT-1:0] axis_dir
);
    localparam int NG = `HWAS_GEN_COUNT;
    localparam int NA = `HWAS_AXIS_COUNT;
    localparam int PW = `HWAS_POS_WIDTH;

    // Pin synchronisers
    logic [8:0]                   pin_meta_q;
    logic [8:0]                   pin_q;
    hwas_pkg::hwas_axis_vec_type  sel_q;
    logic [2:0]                   mode_q;
    hwas_pkg::hwas_gen_type       zsel_q;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pin_meta_q <= 9'h000;
            pin_q      <= 9'h000;
        end
        else
        begin
            pin_meta_q <= {mode_code_bit2, mode_code_bit1, mode_code_bit0,
                           z_gen_select_hi, z_gen_select_lo,
                           fourth_axis_select, third_axis_select,
                           z_axis_select, x_axis_select};
            pin_q      <= pin_meta_q;
        end
    end

    assign sel_q  = pin_q[3:0];
    assign zsel_q = pin_q[5:4];
    assign mode_q = pin_q[8:6];

    // Registers
    hwas_pkg::hwas_byte_type cfg_q;
    hwas_pkg::hwas_byte_type cfg_d;
    hwas_pkg::hwas_byte_type assign_q;
    hwas_pkg::hwas_byte_type assign_d;
    hwas_pkg::hwas_byte_type gain_dir_q;
    hwas_pkg::hwas_byte_type gain_dir_d;
    logic [31:0]             prdata_q;
    logic [31:0]             prdata_d;
    logic                    hit;
    logic                    wr_en;

    logic                    sle;
    logic                    spec_b;
    logic                    third_ok;
    logic [1:0]              ngen;
    logic                    handle_mode;

    assign sle         = cfg_q[`HWAS_CFG_SLE_BIT];
    assign spec_b      = cfg_q[`HWAS_CFG_SPECB_BIT];
    assign third_ok    = cfg_q[`HWAS_CFG_THIRD_BIT];
    assign ngen        = cfg_q[`HWAS_CFG_NGEN_LSB +: 2];
    assign handle_mode = (mode_q == `HWAS_MODE_HANDLE);

    // Axis mapping: generator number per axis, 0 for none
    hwas_pkg::hwas_axis_vec_type sel_eff;
    hwas_pkg::hwas_axis_vec_type pool;
    hwas_pkg::hwas_axis_vec_type rem;
    logic [NG-1:0][NA-1:0]       pick;
    logic [NG-1:0][NA-1:0]       gen_axis;
    hwas_pkg::hwas_gen_type      z_field;
    hwas_pkg::hwas_gen_type      fourth_field;
    logic [NA-1:0][1:0]          axis_src_q;
    logic [NA-1:0][1:0]          axis_src_d;

    assign sel_eff = {sel_q[3], sel_q[2] & third_ok, sel_q[1:0]};
    // Fields above 3 name no generator: Z goes idle, fourth keeps its pool mapping
    assign z_field      = (assign_q[3:2] == 2'h0) ? assign_q[1:0] : 2'h0;
    assign fourth_field = (assign_q[7:6] == 2'h0) ? assign_q[5:4] : 2'h0;

    always_comb
    begin
        // Under spec B the Z axis leaves the selection pool
        pool = spec_b ? (sel_eff & 4'b1101) : sel_eff;
        rem  = pool;
        for (int g = 0; g < NG; g++)
        begin
            pick[g] = rem & (~rem + 4'h1);
            rem     = rem & ~pick[g];
        end
        if (ngen == 2'h3 && !sle)
        begin
            gen_axis = {4'b0100, 4'b0010, 4'b0001};
        end
        else
        begin
            gen_axis[0] = pick[0];
            gen_axis[1] = (ngen >= 2'h2) ? pick[1] : 4'h0;
            gen_axis[2] = (ngen == 2'h3) ? pick[2] : 4'h0;
        end
        axis_src_d = '0;
        for (int a = 0; a < NA; a++)
        begin
            for (int g = 0; g < NG; g++)
            begin
                if (gen_axis[g][a])
                begin
                    axis_src_d[a] = 2'(g + 1);
                end
            end
        end
        if (spec_b)
        begin
            axis_src_d[1] = (zsel_q == 2'h0) ? z_field : zsel_q;
            if (sel_eff[3] && fourth_field != 2'h0)
            begin
                axis_src_d[3] = fourth_field;
            end
        end
        if (!handle_mode)
        begin
            axis_src_d = '0;
        end
    end

    // Step routing and axis positions
    logic [NG-1:0]          gen_step;
    logic [NG-1:0]          gen_dir;
    logic [NA-1:0]          step_q;
    logic [NA-1:0]          step_d;
    logic [NA-1:0]          dir_q;
    logic [NA-1:0]          dir_d;
    logic [NA-1:0][PW-1:0]  pos_q;
    logic [NA-1:0][PW-1:0]  pos_d;

    for (genvar g = 0; g < NG; g++)
    begin : gen_dec
        hwas_quad_decoder u_dec
        (
            .core_clk   (core_clk),
            .resetn     (resetn),
            .phase_a_in (phase_a_in[g]),
            .phase_b_in (phase_b_in[g]),
            .step_pulse (gen_step[g]),
            .step_dir   (gen_dir[g])
        );
    end

    always_comb
    begin
        for (int a = 0; a < NA; a++)
        begin
            step_d[a] = 1'b0;
            dir_d[a]  = dir_q[a];
            pos_d[a]  = pos_q[a];
            if (axis_src_q[a] != 2'h0)
            begin
                step_d[a] = gen_step[axis_src_q[a] - 2'h1];
                // Reverse bit flips the count sense per axis
                dir_d[a]  = gen_dir[axis_src_q[a] - 2'h1] ^ gain_dir_q[a];
            end
            if (step_d[a])
            begin
                pos_d[a] = dir_d[a] ? pos_q[a] + 16'h0001
                                    : pos_q[a] - 16'h0001;
            end
        end
    end

    // APB slave: no wait states, error on unmapped addresses
    always_comb
    begin
        hit      = 1'b1;
        prdata_d = 32'h0000_0000;
        unique case (paddr)
            `HWAS_DGN_ADDR(`HWAS_IDX_X_SEL):
                prdata_d[`HWAS_SEL_BIT] = sel_q[0];
            `HWAS_DGN_ADDR(`HWAS_IDX_Z_SEL):
                prdata_d[`HWAS_SEL_BIT] = sel_q[1];
            `HWAS_DGN_ADDR(`HWAS_IDX_THIRD_SEL):
                prdata_d[`HWAS_SEL_BIT] = sel_q[2];
            `HWAS_DGN_ADDR(`HWAS_IDX_FOURTH_SEL):
                prdata_d[`HWAS_SEL_BIT] = sel_q[3];
            `HWAS_PRM_ADDR(`HWAS_IDX_GEN_ASSIGN):
                prdata_d[7:0] = assign_q;
            `HWAS_PRM_ADDR(`HWAS_IDX_GAIN_DIR):
                prdata_d[7:0] = gain_dir_q;
            `HWAS_PRM_ADDR(`HWAS_IDX_CONFIG):
                prdata_d[7:0] = cfg_q;
            `HWAS_DGN_ADDR(`HWAS_IDX_MAP):
                prdata_d[7:0] = axis_src_q;
            `HWAS_DGN_ADDR(`HWAS_IDX_POS0):
                prdata_d[PW-1:0] = pos_q[0];
            `HWAS_DGN_ADDR(`HWAS_IDX_POS0 + 12'h0001):
                prdata_d[PW-1:0] = pos_q[1];
            `HWAS_DGN_ADDR(`HWAS_IDX_POS0 + 12'h0002):
                prdata_d[PW-1:0] = pos_q[2];
            `HWAS_DGN_ADDR(`HWAS_IDX_POS0 + 12'h0003):
                prdata_d[PW-1:0] = pos_q[3];
            default:
                hit = 1'b0;
        endcase
        if (!(psel && !penable))
        begin
            prdata_d = prdata_q;
        end
        wr_en      = psel && penable && pwrite;
        cfg_d      = cfg_q;
        assign_d   = assign_q;
        gain_dir_d = gain_dir_q;
        if (wr_en && paddr == `HWAS_PRM_ADDR(`HWAS_IDX_CONFIG))
        begin
            cfg_d = pwdata[7:0];
        end
        if (wr_en && paddr == `HWAS_PRM_ADDR(`HWAS_IDX_GEN_ASSIGN))
        begin
            assign_d = pwdata[7:0];
        end
        if (wr_en && paddr == `HWAS_PRM_ADDR(`HWAS_IDX_GAIN_DIR))
        begin
            gain_dir_d = pwdata[7:0];
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cfg_q      <= `HWAS_CONFIG_RST;
            assign_q   <= `HWAS_ASSIGN_RST;
            gain_dir_q <= `HWAS_GAIN_DIR_RST;
            prdata_q   <= 32'h0000_0000;
            axis_src_q <= '0;
            step_q     <= '0;
            dir_q      <= '0;
            pos_q      <= '0;
        end
        else
        begin
            cfg_q      <= cfg_d;
            assign_q   <= assign_d;
            gain_dir_q <= gain_dir_d;
            prdata_q   <= prdata_d;
            axis_src_q <= axis_src_d;
            step_q     <= step_d;
            dir_q      <= dir_d;
            pos_q      <= pos_d;
        end
    end

    assign prdata    = prdata_q;
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !hit;
    assign axis_step = step_q;
    assign axis_dir  = dir_q;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_read_x;
        psel && !penable && !pwrite
            && paddr == `HWAS_DGN_ADDR(`HWAS_IDX_X_SEL);
    endsequence

    a_mode_gates_map: assert property (
        !handle_mode |=> axis_src_q == '0)
        else $error("axis mapped outside handle mode");
    a_specb_z_code: assert property (
        handle_mode && spec_b && zsel_q == 2'h2
        |=> axis_src_q[1] == 2'h2)
        else $error("spec B Z code 10 not second generator");
    a_specb_z_param: assert property (
        handle_mode && spec_b && zsel_q == 2'h0
        |=> axis_src_q[1] == $past(z_field))
        else $error("spec B Z not from assignment parameter");
    a_third_gated: assert property (
        handle_mode && !spec_b && !third_ok && sel_q == 4'b0100
            && (ngen != 2'h3 || sle)
        |=> axis_src_q == '0)
        else $error("third select used while disabled");
    a_single_wheel: assert property (
        handle_mode && !spec_b && ngen == 2'h1 && sel_q == 4'b0001
        |=> axis_src_q == 8'h01)
        else $error("single handwheel not on X");
    a_dual_priority: assert property (
        handle_mode && !spec_b && ngen == 2'h2 && sel_eff == 4'b1101
        |=> axis_src_q == 8'h21)
        else $error("dual handwheel priority wrong");
    a_fixed_three: assert property (
        handle_mode && !spec_b && ngen == 2'h3 && !sle
        |=> axis_src_q == 8'h39)
        else $error("fixed three-wheel mapping wrong");
    a_step_route: assert property (
        axis_src_q[0] == 2'h1 && gen_step[0]
        |=> axis_step[0] && pos_q[0] != $past(pos_q[0]))
        else $error("generator step did not move X");
    a_select_read: assert property (
        s_read_x ##1 psel && penable
        |-> prdata[`HWAS_SEL_BIT] == $past(sel_q[0]))
        else $error("X select not seen at bit 7");
endmodule
`default_nettype wire

// *** bench/hwas_plc_model.sv ***
// Far-side model: PLC select pins and three handwheel generators
`default_nettype none
module hwas_plc_model
(
    input  wire logic       core_clk,
    output var  logic       x_axis_select,
    output var  logic       z_axis_select,
    output var  logic       third_axis_select,
    output var  logic       fourth_axis_select,
    output var  logic       z_gen_select_hi,
    output var  logic       z_gen_select_lo,
    output var  logic       mode_code_bit2,
    output var  logic       mode_code_bit1,
    output var  logic       mode_code_bit0,
    output var  logic [2:0] phase_a_in,
    output var  logic [2:0] phase_b_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] s;
    initial
    begin
        {x_axis_select, z_axis_select, third_axis_select} = 3'h0;
        {fourth_axis_select, z_gen_select_hi, z_gen_select_lo} = 3'h0;
        {mode_code_bit2, mode_code_bit1, mode_code_bit0} = 3'h0;
        phase_a_in = 3'h0;
        phase_b_in = 3'h0;
    end
    task set_sel(input logic [3:0] sel, input logic [2:0] mode,
                 input logic [1:0] zc);
        @(posedge core_clk);
        x_axis_select      <= sel[0];
        z_axis_select      <= sel[1];
        third_axis_select  <= sel[2];
        fourth_axis_select <= sel[3];
        {mode_code_bit2, mode_code_bit1, mode_code_bit0} <= mode;
        {z_gen_select_hi, z_gen_select_lo} <= zc;
    endtask
    // One phase edge per detent, held past the synchroniser
    task turn(input int g, input int n, input logic fw);
        repeat (n)
        begin
            s = {phase_a_in[g], phase_b_in[g]};
            s = fw ? {s[0], ~s[1]} : {~s[0], s[1]};
            @(posedge core_clk);
            phase_a_in[g] <= s[1];
            phase_b_in[g] <= s[0];
            repeat (6) @(posedge core_clk);
        end
    endtask
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the handwheel axis selector
`include "hwas_cfg.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] CFG = `HWAS_PRM_ADDR(`HWAS_IDX_CONFIG);
    localparam logic [11:0] ASG = `HWAS_PRM_ADDR(`HWAS_IDX_GEN_ASSIGN);
    localparam logic [11:0] GDR = `HWAS_PRM_ADDR(`HWAS_IDX_GAIN_DIR);
    localparam logic [11:0] MAP = `HWAS_DGN_ADDR(`HWAS_IDX_MAP);
    localparam logic [11:0] SEL = `HWAS_DGN_ADDR(`HWAS_IDX_X_SEL);
    localparam logic [11:0] POS = `HWAS_DGN_ADDR(`HWAS_IDX_POS0);
    logic        core_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    wire  logic  xs, zs, ts, fs, zh, zl, m2, m1, m0;
    wire  logic [2:0] pa, pb;
    logic [3:0]  axis_step;
    logic [3:0]  axis_dir;
    int          mismatches = 0;
    int          checked = 0;
    int          steps[4] = '{0, 0, 0, 0};
    int          fwd[4] = '{0, 0, 0, 0};

    always #2 core_clk = ~core_clk;

    hwas_plc_model plc_u
    (
        .core_clk(core_clk), .x_axis_select(xs), .z_axis_select(zs),
        .third_axis_select(ts), .fourth_axis_select(fs),
        .z_gen_select_hi(zh), .z_gen_select_lo(zl), .mode_code_bit2(m2),
        .mode_code_bit1(m1), .mode_code_bit0(m0), .phase_a_in(pa),
        .phase_b_in(pb)
    );
    hwas_selector dut_u
    (
        .core_clk(core_clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .x_axis_select(xs), .z_axis_select(zs),
        .third_axis_select(ts), .fourth_axis_select(fs),
        .z_gen_select_hi(zh), .z_gen_select_lo(zl), .mode_code_bit2(m2),
        .mode_code_bit1(m1), .mode_code_bit0(m0), .phase_a_in(pa),
        .phase_b_in(pb), .axis_step(axis_step), .axis_dir(axis_dir)
    );

    // Pulses are counted here so step tests need no exact latency
    always @(posedge core_clk)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (axis_step[i] === 1'b1)
            begin
                steps[i]++;
                fwd[i] += (axis_dir[i] === 1'b1);
            end
        end
    end

    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        // Only the watchdog ends an unanswered access
        while (pready !== 1'b1)
        begin
            @(posedge core_clk);
        end
        chk("pready", 1'b1, pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
    endtask

    task automatic rdc(input string nm, input logic [11:0] a,
                       input logic [31:0] e, input logic ee);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0000_0000, rd, err);
        chk(nm, e, rd);
        chk("pslverr", ee, err);
    endtask

    task automatic map_chk(input logic [3:0] sel, input logic [1:0] zc,
                           input logic [31:0] e);
        plc_u.set_sel(sel, 3'h1, zc);
        repeat (4) @(posedge core_clk);
        rdc("map", MAP, e, 1'b0);
    endtask

    task automatic t_reset_regs;
        rdc("config", CFG, 32'h0000_0004, 1'b0);
        rdc("assign", ASG, 32'h0000_0000, 1'b0);
        rdc("gain dir", GDR, 32'h0000_0000, 1'b0);
        rdc("unmapped", 12'h7F0, 32'h0000_0000, 1'b1);
        wr(SEL, 32'h0000_0080);
        rdc("x select ro", SEL, 32'h0000_0000, 1'b0);
    endtask

    task automatic t_one_wheel;
        wr(CFG, 32'h0000_0024);
        map_chk(4'h0, 2'h0, 32'h0000_0000);
        for (int i = 0; i < 4; i++)
        begin
            map_chk(4'h1 << i, 2'h0, 32'h1 << (2 * i));
            rdc("select byte", SEL + 12'(4 * i), 32'h0000_0080, 1'b0);
        end
        // Extra selects are ignored: Z outranks third
        map_chk(4'h6, 2'h0, 32'h0000_0004);
    endtask

    task automatic t_two_wheels;
        wr(CFG, 32'h0000_0028);
        map_chk(4'h7, 2'h0, 32'h0000_0009);
        map_chk(4'hC, 2'h0, 32'h0000_0090);
        map_chk(4'hA, 2'h0, 32'h0000_0084);
        map_chk(4'hF, 2'h0, 32'h0000_0009);
        map_chk(4'hD, 2'h0, 32'h0000_0021);
        wr(CFG, 32'h0000_0008);
        map_chk(4'hC, 2'h0, 32'h0000_0040);
        map_chk(4'h4, 2'h0, 32'h0000_0000);
    endtask

    task automatic t_three_wheels;
        wr(CFG, 32'h0000_000C);
        map_chk(4'h0, 2'h0, 32'h0000_0039);
        wr(CFG, 32'h0000_002D);
        map_chk(4'hD, 2'h0, 32'h0000_00E1);
        map_chk(4'h9, 2'h0, 32'h0000_0081);
    endtask

    task automatic t_spec_b;
        wr(CFG, 32'h0000_002F);
        wr(ASG, 32'h0000_0132);
        rdc("assign", ASG, 32'h0000_0032, 1'b0);
        for (int c = 1; c < 4; c++)
            map_chk(4'h0, c[1:0], 32'h0 | (c << 2));
        map_chk(4'h0, 2'h0, 32'h0000_0008);
        map_chk(4'h9, 2'h0, 32'h0000_00C9);
    endtask

    task automatic turn_chk(input logic fw, input int es, input int ef);
        int s0;
        int f0;
        int z0;
        s0 = steps[0];
        f0 = fwd[0];
        z0 = steps[1];
        plc_u.turn(0, 4, fw);
        repeat (8) @(posedge core_clk);
        chk("x steps", es, steps[0] - s0);
        chk("x forward", ef, fwd[0] - f0);
        chk("z steps", 0, steps[1] - z0);
    endtask

    task automatic t_steps;
        wr(CFG, 32'h0000_0024);
        plc_u.set_sel(4'h1, 3'h1, 2'h0);
        repeat (4) @(posedge core_clk);
        turn_chk(1'b1, 4, 4);
        turn_chk(1'b0, 4, 0);
        wr(GDR, 32'h0000_0001);
        turn_chk(1'b1, 4, 0);
        plc_u.set_sel(4'h1, 3'h0, 2'h0);
        repeat (4) @(posedge core_clk);
        turn_chk(1'b1, 0, 0);
        // Net count: up four, down four, then four reversed
        rdc("x position", POS, 32'h0000_FFFC, 1'b0);
        rdc("z position", POS + 12'h004, 32'h0000_0000, 1'b0);
    endtask

    initial
    begin
        #60000;
        mismatches++;
        tally_and_finish();
    end

    initial
    begin
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        t_reset_regs();
        t_one_wheel();
        t_two_wheels();
        t_three_wheels();
        t_spec_b();
        t_steps();
        tally_and_finish();
    end
endmodule
`default_nettype wire
